// ===== shared/lshp_cfg.svh
`ifndef LSHP_CFG_SVH
`define LSHP_CFG_SVH
`define LSHP_NUM_POINTS 10
`define LSHP_TRIG_MIN_NS 1000
`define LSHP_CLK_NS 20
`define LSHP_TRIG_MIN_CYC ((`LSHP_TRIG_MIN_NS + `LSHP_CLK_NS - 1) / `LSHP_CLK_NS)
`define LSHP_PINS_IDLE 1'b1
`endif

// ===== shared/lshp_pkg.sv
package lshp_pkg;
  typedef enum logic {LSHP_SEQUENTIAL, LSHP_STEPPING} lshp_mode_t;
  typedef enum logic [1:0] {LSHP_IDLE, LSHP_MEAS, LSHP_DONE} lshp_state_t;
endpackage

// ===== logic/lshp_sync.sv
`timescale 1ns/100ps
`include "lshp_cfg.svh"
module lshp_sync (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RESETN,
  // Raw and filtered level
  input  wire logic din,
  output logic      dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // A change counts only when the second and third stages agree.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s1_r <= `LSHP_PINS_IDLE;
      s2_r <= `LSHP_PINS_IDLE;
      s3_r <= `LSHP_PINS_IDLE;
      dout <= `LSHP_PINS_IDLE;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule

// ===== logic/lshp_top.sv
`timescale 1ns/100ps
`include "lshp_cfg.svh"
module lshp_top #(
  parameter int NPTS = `LSHP_NUM_POINTS
) (
  // Clock and reset
  input  wire logic            CLK,
  input  wire logic            RESETN,
  // Configuration from the instrument core
  input  wire logic            EXTERNAL_TRIGGER_MODE,
  input  wire lshp_pkg::lshp_mode_t SWEEP_MODE,
  // Measurement engine events
  input  wire logic            INT_TRIGGER,
  input  wire logic            ANALOG_DONE_IN,
  input  wire logic            STEP_DONE_IN,
  input  wire logic            SWEEP_DONE_IN,
  input  wire logic [NPTS-1:0] POINT_FAIL_IN,
  input  wire logic            PRI_HIGH_IN,
  input  wire logic            PRI_LOW_IN,
  input  wire logic            SEC_OUT_IN,
  input  wire logic            POWER_FAIL_IN,
  // Front panel
  input  wire logic [7:0]      PANEL_KEYS_IN,
  output logic [7:0]           PANEL_KEYS_OUT,
  // Start request to the measurement engine
  output logic                 MEAS_START,
  // Handler pins, active low
  input  wire logic            EXTERNAL_TRIGGER_IN_N,
  input  wire logic            PANEL_LOCK_N,
  output logic [8:0]           POINT_FAIL_N,
  output logic                 POINT10_FAIL_N,
  output logic                 REJECT_N,
  output logic                 PRIMARY_HIGH_N,
  output logic                 PRIMARY_LOW_N,
  output logic                 SECONDARY_REJECT_N,
  output logic                 ANALOG_DONE_N,
  output logic                 CYCLE_COMPLETE_N,
  output logic                 SUPPLY_ALARM_N
);
  localparam int CW = $clog2(`LSHP_TRIG_MIN_CYC + 1);
  localparam logic [CW-1:0] TRIG_MIN = CW'(`LSHP_TRIG_MIN_CYC);

  lshp_pkg::lshp_state_t state_r, state_nxt;
  logic          trig_s;
  logic          lock_s;
  logic          trig_prev_r;
  logic [CW-1:0] hi_cnt_r;
  logic          armed_r;
  logic [CW-1:0] act_run_r;

  lshp_sync u_trig (
    .CLK    (CLK),
    .RESETN (RESETN),
    .din    (EXTERNAL_TRIGGER_IN_N),
    .dout   (trig_s)
  );

  lshp_sync u_lock (
    .CLK    (CLK),
    .RESETN (RESETN),
    .din    (PANEL_LOCK_N),
    .dout   (lock_s)
  );

  // The pin is active low, so the asserted edge is the falling level.
  wire trig_active = ~trig_s;
  wire trig_rise   = trig_active & ~trig_prev_r;
  // A short glitch is not a trigger; the pulse is accepted once wide enough.
  wire ext_fire    = armed_r & trig_active &
                     (hi_cnt_r == TRIG_MIN);
  wire start       = (state_r != lshp_pkg::LSHP_MEAS) &
                     (EXTERNAL_TRIGGER_MODE ? ext_fire :
                      INT_TRIGGER);
  wire stepping    = (SWEEP_MODE == lshp_pkg::LSHP_STEPPING);
  wire adone_ev    = stepping ? ANALOG_DONE_IN : SWEEP_DONE_IN;
  wire cdone_ev    = stepping ? STEP_DONE_IN : SWEEP_DONE_IN;
  wire any_fail    = |POINT_FAIL_IN;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      lshp_pkg::LSHP_IDLE: if (start) state_nxt = lshp_pkg::LSHP_MEAS;
      lshp_pkg::LSHP_MEAS: if (SWEEP_DONE_IN) state_nxt = lshp_pkg::LSHP_DONE;
      lshp_pkg::LSHP_DONE: if (start) state_nxt = lshp_pkg::LSHP_MEAS;
      default: state_nxt = lshp_pkg::LSHP_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      trig_prev_r <= 1'b0;
      hi_cnt_r    <= '0;
      armed_r     <= 1'b0;
      act_run_r   <= '0;
    end else begin
      trig_prev_r <= trig_active;
      if (!trig_active) begin
        act_run_r <= '0;
      end else if (act_run_r != TRIG_MIN) begin
        act_run_r <= act_run_r + CW'(1);
      end
      if (trig_rise) begin
        armed_r  <= 1'b1;
        // The edge cycle is already the first active one, so a pulse of
        // exactly the minimum width is still accepted.
        hi_cnt_r <= CW'(2);
      end else if (!trig_active || ext_fire) begin
        armed_r  <= 1'b0;
      end else if (hi_cnt_r != TRIG_MIN) begin
        hi_cnt_r <= hi_cnt_r + CW'(1);
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r            <= lshp_pkg::LSHP_IDLE;
      MEAS_START         <= 1'b0;
      POINT_FAIL_N       <= {9{`LSHP_PINS_IDLE}};
      POINT10_FAIL_N     <= `LSHP_PINS_IDLE;
      REJECT_N           <= `LSHP_PINS_IDLE;
      PRIMARY_HIGH_N     <= `LSHP_PINS_IDLE;
      PRIMARY_LOW_N      <= `LSHP_PINS_IDLE;
      SECONDARY_REJECT_N <= `LSHP_PINS_IDLE;
      ANALOG_DONE_N      <= `LSHP_PINS_IDLE;
      CYCLE_COMPLETE_N   <= `LSHP_PINS_IDLE;
      SUPPLY_ALARM_N     <= `LSHP_PINS_IDLE;
      PANEL_KEYS_OUT     <= 8'h00;
    end else begin
      state_r        <= state_nxt;
      MEAS_START     <= start;
      SUPPLY_ALARM_N <= ~POWER_FAIL_IN;
      PANEL_KEYS_OUT <= lock_s ? PANEL_KEYS_IN : 8'h00;
      if (start) begin
        // Handshakes fall back; results stay until the new sweep ends.
        ANALOG_DONE_N    <= 1'b1;
        CYCLE_COMPLETE_N <= 1'b1;
      end else if (state_r == lshp_pkg::LSHP_MEAS) begin
        if (adone_ev) ANALOG_DONE_N <= 1'b0;
        if (cdone_ev) begin
          CYCLE_COMPLETE_N <= 1'b0;
        end
        if (SWEEP_DONE_IN) begin
          // Results land together with the handshake they qualify.
          POINT_FAIL_N       <= ~POINT_FAIL_IN[8:0];
          POINT10_FAIL_N     <= ~POINT_FAIL_IN[9];
          REJECT_N           <= ~any_fail;
          PRIMARY_HIGH_N     <= ~PRI_HIGH_IN;
          PRIMARY_LOW_N      <= ~PRI_LOW_IN;
          SECONDARY_REJECT_N <= ~SEC_OUT_IN;
          CYCLE_COMPLETE_N   <= 1'b0;
          ANALOG_DONE_N      <= 1'b0;
        end
      end
    end
  end

  a_cc_with_results: assert property (
    @(posedge CLK) disable iff (!RESETN)
    ($past(state_r) == lshp_pkg::LSHP_MEAS && $past(SWEEP_DONE_IN) &&
     !$past(start)) |-> (!CYCLE_COMPLETE_N &&
     REJECT_N == ~(|$past(POINT_FAIL_IN))))
    else $error("Cycle complete without matching reject");

  a_hold_results: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (state_r == lshp_pkg::LSHP_DONE && !start) |=>
    $stable(POINT_FAIL_N) && $stable(REJECT_N) && $stable(POINT10_FAIL_N))
    else $error("Results changed before next trigger");

  a_start_on_edge: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (EXTERNAL_TRIGGER_MODE && state_r != lshp_pkg::LSHP_MEAS &&
     ext_fire) |=> MEAS_START)
    else $error("Trigger edge did not start a measurement");

  a_no_short_trig: assert property (
    @(posedge CLK) disable iff (!RESETN)
    ext_fire |-> trig_active && act_run_r >= TRIG_MIN - CW'(1))
    else $error("Trigger accepted before minimum width");

  a_key_lock: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !lock_s |=> PANEL_KEYS_OUT == 8'h00)
    else $error("Keys passed while locked");

  a_alarm: assert property (
    @(posedge CLK) disable iff (!RESETN)
    POWER_FAIL_IN |=> !SUPPLY_ALARM_N)
    else $error("Alarm missing on power failure");

  a_seq_adone: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (!stepping && state_r == lshp_pkg::LSHP_MEAS && !SWEEP_DONE_IN &&
     !start && ANALOG_DONE_N) |=> ANALOG_DONE_N)
    else $error("Sequential analog done before sweep end");

  a_step_adone: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (stepping && state_r == lshp_pkg::LSHP_MEAS && ANALOG_DONE_IN &&
     !start) |=> !ANALOG_DONE_N)
    else $error("Stepping analog done missing");

  a_step_cc: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (stepping && state_r == lshp_pkg::LSHP_MEAS && STEP_DONE_IN) |=>
    !CYCLE_COMPLETE_N)
    else $error("Stepping cycle complete missing");

  a_primary_low: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (state_r == lshp_pkg::LSHP_MEAS && SWEEP_DONE_IN && !start) |=>
    PRIMARY_LOW_N == ~$past(PRI_LOW_IN))
    else $error("Primary low not latched");
endmodule

// ===== test/lshp_handler.sv
`timescale 1ns/100ps
module lshp_handler (
  // Clock
  input  wire logic clk,
  // Trigger pin, driven idle high by the handler
  output logic      trig_n
);
  initial trig_n = 1'b1;
  // The pulse width is in clock cycles, so a short one can be refused.
  task automatic fire(input int cyc);
    @(posedge clk) #2 trig_n = 1'b0;
    repeat (cyc) @(posedge clk);
    #2 trig_n = 1'b1;
  endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic                 clk;
  logic                 resetn;
  logic                 ext_mode;
  lshp_pkg::lshp_mode_t mode;
  logic [3:0]           ev_v;
  logic [9:0]           pfail;
  logic [2:0]           par;
  logic                 pwr;
  logic                 lock_n;
  logic [7:0]           keys;
  logic [7:0]           keys_out;
  logic                 start;
  logic                 trig_n;
  logic [8:0]           pf_n;
  logic                 p10_n, rej_n, phi_n, plo_n, secondary_reject_n, ad_n, cc_n, al_n;
  int                   n_fail, tests_run, n_start;
  lshp_handler i_hdl (.clk(clk), .trig_n(trig_n));
  lshp_top i_dut (
    .CLK(clk), .RESETN(resetn), .EXTERNAL_TRIGGER_MODE(ext_mode),
    .SWEEP_MODE(mode), .INT_TRIGGER(ev_v[0]), .ANALOG_DONE_IN(ev_v[1]),
    .STEP_DONE_IN(ev_v[2]), .SWEEP_DONE_IN(ev_v[3]), .POINT_FAIL_IN(pfail),
    .PRI_HIGH_IN(par[2]), .PRI_LOW_IN(par[1]), .SEC_OUT_IN(par[0]),
    .POWER_FAIL_IN(pwr), .PANEL_KEYS_IN(keys), .PANEL_KEYS_OUT(keys_out),
    .MEAS_START(start), .EXTERNAL_TRIGGER_IN_N(trig_n),
    .PANEL_LOCK_N(lock_n), .POINT_FAIL_N(pf_n), .POINT10_FAIL_N(p10_n),
    .REJECT_N(rej_n), .PRIMARY_HIGH_N(phi_n), .PRIMARY_LOW_N(plo_n),
    .SECONDARY_REJECT_N(secondary_reject_n), .ANALOG_DONE_N(ad_n),
    .CYCLE_COMPLETE_N(cc_n), .SUPPLY_ALARM_N(al_n));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (start === 1'b1) n_start++;
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic ev(input int k);
    ev_v[k] = 1'b1;
    tick(1);
    ev_v[k] = 1'b0;
  endtask
  task automatic res(input logic [9:0] f, input logic [2:0] p);
    chk("results", {2'h0, ~f, ~|f, ~p},
        {2'h0, p10_n, pf_n, rej_n, phi_n, plo_n, secondary_reject_n});
  endtask
  task automatic hs(input logic [1:0] e);
    chk("handshakes", {14'h0, e}, {14'h0, ad_n, cc_n});
  endtask
  // The bound covers the one-cycle answer plus margin; a miss is fatal.
  task automatic go();
    int s;
    s = n_start;
    ev(0);
    for (int i = 0; i < 8 && n_start == s; i++) tick(1);
    chk("start", 16'h1, 16'(n_start - s));
    if (n_start == s) results();
    tick(1);
    hs(2'h3);
  endtask
  task automatic s_seq();
    mode = lshp_pkg::LSHP_SEQUENTIAL;
    go();
    pfail = 10'h201;
    par = 3'h5;
    ev(1);
    tick(1);
    hs(2'h3);
    ev(3);
    tick(1);
    hs(2'h0);
    res(10'h201, 3'h5);
    pfail = 10'h0;
    par = 3'h0;
    tick(4);
    res(10'h201, 3'h5);
  endtask
  task automatic s_step();
    int s;
    mode = lshp_pkg::LSHP_STEPPING;
    go();
    s = n_start;
    ev(0);
    tick(3);
    chk("restart", 16'h0, 16'(n_start - s));
    ev(1);
    tick(1);
    hs(2'h1);
    ev(2);
    tick(1);
    hs(2'h0);
    res(10'h201, 3'h5);
    pfail = 10'h100;
    par = 3'h2;
    ev(3);
    tick(1);
    res(10'h100, 3'h2);
    hs(2'h0);
  endtask
  // One cycle short of the minimum width, then exactly the minimum.
  task automatic s_ext();
    int s;
    ext_mode = 1'b1;
    s = n_start;
    i_hdl.fire(49);
    tick(8);
    chk("short trigger", 16'h0, 16'(n_start - s));
    i_hdl.fire(50);
    tick(8);
    chk("trigger", 16'h1, 16'(n_start - s));
  endtask
  task automatic s_panel();
    keys = 8'ha5;
    tick(2);
    chk("keys", 16'ha5, {8'h0, keys_out});
    lock_n = 1'b0;
    tick(6);
    chk("locked keys", 16'h0, {8'h0, keys_out});
    lock_n = 1'b1;
    tick(6);
    chk("keys", 16'ha5, {8'h0, keys_out});
    pwr = 1'b1;
    tick(2);
    chk("alarm", 16'h0, {15'h0, al_n});
    pwr = 1'b0;
    tick(2);
    chk("alarm", 16'h1, {15'h0, al_n});
  endtask
  initial begin
    {ext_mode, ev_v, pfail, par, pwr, keys} = 27'h0;
    mode = lshp_pkg::LSHP_SEQUENTIAL;
    lock_n = 1'b1;
    resetn = 1'b0;
    tick(6);
    resetn = 1'b1;
    tick(1);
    res(10'h0, 3'h0);
    hs(2'h3);
    s_seq();
    s_step();
    s_ext();
    s_panel();
    results();
  end
  initial begin
    #1500000;
    n_fail++;
    results();
  end
endmodule
